// *** rtl/wdt_pkg.sv ***
package wdt_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] WATCHDOG_SELECT_ADDR = 8'h09;
    localparam logic [7:0] STATUS_ADDR = 8'h0A;
    localparam logic [7:0] WATCHDOG_SELECT_RESET = 8'h07;
    localparam int RATIO_SEL_LSB = 0;
    localparam int TIMEOUT_FLAG_BIT = 5;
    localparam int POWER_DOWN_FLAG_BIT = 4;

    // ==========================================================
    // Timing
    localparam int FIXED_DIV_STAGES = 8;
    localparam int INSTR_CLK_DIV = 4;
    localparam int SETTLE_CYCLES = 1024;
    localparam logic [10:0] SETTLE_LAST = 11'h3FF;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

    // ==========================================================
    // Option, state and wake-cause types
    typedef enum logic [1:0] {
        SRC_RC_OSC = 2'h0,
        SRC_CRYSTAL = 2'h1,
        SRC_INSTR = 2'h2
    } wdt_src_t;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_HALT = 4'h2,
        ST_SETTLE = 4'h4,
        ST_RESET = 4'h8
    } pwr_state_t;

    typedef enum logic [1:0] {
        WAKE_NONE = 2'h0,
        WAKE_PORT = 2'h1,
        WAKE_IRQ = 2'h2,
        WAKE_WDT = 2'h3
    } wake_cause_t;

    typedef struct packed {
        pwr_state_t st;
        logic [7:0] sel;
        logic [7:0] fixed_cnt;
        logic [7:0] pre_cnt;
        logic [1:0] instr_div;
        logic [10:0] settle_cnt;
        logic timeout_flag;
        logic power_down_flag;
        logic first_seen;
        logic second_seen;
        logic [7:0] port_prev;
        logic [7:0] irq_mask_at_halt;
        wake_cause_t cause;
        logic chip_reset;
        logic warm_reset;
        logic sys_clk_en;
        logic resume;
        logic irq_entry;
        logic [7:0] rdata;
    } wdt_state_t;

endpackage

// *** rtl/watchdog_halt_wakeup.sv ***
// Function
// - Watchdog clock from RC oscillator, crystal timebase, or instruction clock (sys/4).
// - Disabled watchdog ignores all watchdog actions and never times out.
// - RC oscillator source first passes a fixed 8-stage divide-by-256.
// - Ratio field bits 2..0 give extra prescale of two to its value.
// - Bit 3 and high nibble are plain software flag storage.
// - Instruction-clock source stops counting during halt.
// - Overflow in normal run gives chip reset and sets time-out flag.
// - Overflow in halt gives warm reset of program counter and stack pointer.
// - Reset pin, clear op or halt op clear counter and prescaler.
// - Single-clear needs one op; dual-clear needs both first and second ops.
// - Halt stops system clock; RC oscillator keeps running if selected.
// - Halt keeps RAM, registers and ports unchanged.
// - Halt clears counter and prescaler, then they count again from zero.
// - Halt sets power-down flag and clears time-out flag.
// - Power-down flag cleared only by power-up or clear op.
// - Halt ends on reset, interrupt, enabled port A falling edge, overflow.
// - Each port A pin has its own wake-up enable option.
// - Port wake-up resumes at instruction after halt.
// - Interrupt wake-up resumes next instruction unless enabled and stack not full.
// - Interrupt already pending at halt entry cannot wake the device.
// - Every wake-up inserts 1024 system clock periods before resuming.
// - Time-out flag cleared by power-up, clear op, halt; set only by time-out.
`timescale 1ns/1ps
`default_nettype none
module watchdog_halt_wakeup
    import wdt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic external_reset_pin,
    input wire logic wdt_enable_opt,
    input wire logic [1:0] wdt_src_opt,
    input wire logic dual_clear_opt,
    input wire logic [7:0] port_wake_en_opt,
    input wire logic rc_osc_tick,
    input wire logic crystal_tick,
    input wire logic clear_watchdog_op,
    input wire logic first_clear_op,
    input wire logic second_clear_op,
    input wire logic halt_op,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] irq_pending,
    input wire logic irq_enabled,
    input wire logic stack_full,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    output logic chip_reset,
    output logic warm_reset,
    output logic sys_clk_en,
    output logic resume,
    output logic irq_entry,
    output logic timeout_flag,
    output logic power_down_flag
);

    // ==========================================================
    // State
    wdt_state_t s_r;
    wdt_state_t s_nxt;

    logic tick;
    logic wdt_clear;
    logic do_halt;
    logic overflow;
    logic fixed_wrap;
    logic [7:0] pre_last;
    logic [7:0] port_fall;
    logic [7:0] irq_new;

    // ==========================================================
    // Watchdog clock selection
    always_comb begin
        unique case (wdt_src_t'(wdt_src_opt))
            SRC_RC_OSC: tick = rc_osc_tick;
            SRC_CRYSTAL: tick = crystal_tick;
            SRC_INSTR: tick = (s_r.instr_div == INSTR_DIV_LAST) && s_r.sys_clk_en;
            default: tick = 1'b0;
        endcase
    end

    // ==========================================================
    // Combinational next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        s_nxt.chip_reset = 1'b0;
        s_nxt.warm_reset = 1'b0;
        s_nxt.resume = 1'b0;
        s_nxt.irq_entry = 1'b0;
        s_nxt.port_prev = port_a_in;
        port_fall = s_r.port_prev & ~port_a_in & port_wake_en_opt;
        irq_new = irq_pending & ~s_r.irq_mask_at_halt;
        do_halt = halt_op && (s_r.st == ST_RUN);
        // Dual mode clears only once both halves are seen, in either order
        wdt_clear = 1'b0;
        if (wdt_enable_opt && (s_r.st == ST_RUN)) begin
            if (!dual_clear_opt) begin
                wdt_clear = clear_watchdog_op;
            end else begin
                if (first_clear_op) begin
                    s_nxt.first_seen = 1'b1;
                end
                if (second_clear_op) begin
                    s_nxt.second_seen = 1'b1;
                end
                if ((s_r.first_seen || first_clear_op) && (s_r.second_seen || second_clear_op)) begin
                    wdt_clear = 1'b1;
                    s_nxt.first_seen = 1'b0;
                    s_nxt.second_seen = 1'b0;
                end
            end
        end
        pre_last = (8'h01 << s_r.sel[2:0]) - 8'h01;
        fixed_wrap = 1'b0;
        overflow = 1'b0;
        if (wdt_enable_opt && tick && (s_r.st != ST_RESET) && (s_r.st != ST_SETTLE)) begin
            if (wdt_src_t'(wdt_src_opt) == SRC_RC_OSC) begin
                s_nxt.fixed_cnt = s_r.fixed_cnt + 8'h01;
                fixed_wrap = (s_r.fixed_cnt == 8'hFF);
            end else begin
                fixed_wrap = 1'b1;
            end
            if (fixed_wrap) begin
                if (s_r.pre_cnt == pre_last) begin
                    s_nxt.pre_cnt = 8'h00;
                    overflow = 1'b1;
                end else begin
                    s_nxt.pre_cnt = s_r.pre_cnt + 8'h01;
                end
            end
        end
        if (s_r.sys_clk_en) begin
            s_nxt.instr_div = s_r.instr_div + 2'h1;
        end
        // Register port: status flags are read-only, writes never touch them
        if (wr_stb && (addr == WATCHDOG_SELECT_ADDR)) begin
            s_nxt.sel = wdata;
        end
        if (rd_stb) begin
            unique case (addr)
                WATCHDOG_SELECT_ADDR: s_nxt.rdata = s_r.sel;
                STATUS_ADDR: begin
                    s_nxt.rdata[TIMEOUT_FLAG_BIT] = s_r.timeout_flag;
                    s_nxt.rdata[POWER_DOWN_FLAG_BIT] = s_r.power_down_flag;
                end
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        if (wdt_clear || do_halt) begin
            s_nxt.fixed_cnt = 8'h00;
            s_nxt.pre_cnt = 8'h00;
        end
        if (wdt_clear) begin
            s_nxt.timeout_flag = 1'b0;
            s_nxt.power_down_flag = 1'b0;
        end
        unique case (s_r.st)
            ST_RUN: begin
                if (do_halt) begin
                    s_nxt.st = ST_HALT;
                    s_nxt.sys_clk_en = 1'b0;
                    s_nxt.power_down_flag = 1'b1;
                    s_nxt.timeout_flag = 1'b0;
                    s_nxt.irq_mask_at_halt = irq_pending;
                    s_nxt.first_seen = 1'b0;
                    s_nxt.second_seen = 1'b0;
                end else if (overflow) begin
                    s_nxt.timeout_flag = 1'b1;
                    s_nxt.chip_reset = 1'b1;
                    s_nxt.st = ST_RESET;
                    s_nxt.settle_cnt = 11'h000;
                    s_nxt.sel = WATCHDOG_SELECT_RESET;
                    s_nxt.fixed_cnt = 8'h00;
                    s_nxt.pre_cnt = 8'h00;
                    // A half-done dual clear must not survive the chip reset
                    s_nxt.first_seen = 1'b0;
                    s_nxt.second_seen = 1'b0;
                end
            end
            ST_HALT: begin
                // Timeout outranks other wake sources to report the flag
                if (overflow) begin
                    s_nxt.timeout_flag = 1'b1;
                    s_nxt.cause = WAKE_WDT;
                    s_nxt.st = ST_SETTLE;
                end else if (|irq_new) begin
                    s_nxt.cause = WAKE_IRQ;
                    s_nxt.st = ST_SETTLE;
                end else if (|port_fall) begin
                    s_nxt.cause = WAKE_PORT;
                    s_nxt.st = ST_SETTLE;
                end
                if (s_nxt.st == ST_SETTLE) begin
                    s_nxt.sys_clk_en = 1'b1;
                    s_nxt.settle_cnt = 11'h000;
                end
            end
            ST_SETTLE, ST_RESET: begin
                s_nxt.settle_cnt = s_r.settle_cnt + 11'h001;
                if (s_r.settle_cnt == SETTLE_LAST) begin
                    s_nxt.st = ST_RUN;
                    s_nxt.chip_reset = 1'b0;
                    if (s_r.st == ST_SETTLE) begin
                        unique case (s_r.cause)
                            WAKE_WDT: s_nxt.warm_reset = 1'b1;
                            WAKE_IRQ: begin
                                s_nxt.irq_entry = irq_enabled && !stack_full;
                                s_nxt.resume = !(irq_enabled && !stack_full);
                            end
                            default: s_nxt.resume = 1'b1;
                        endcase
                    end
                    s_nxt.cause = WAKE_NONE;
                end else if (s_r.st == ST_RESET) begin
                    s_nxt.chip_reset = 1'b1;
                end
            end
            default: s_nxt.st = ST_RESET;
        endcase
        // Reset pin during run or halt re-initialises; flags keep meaning
        if (!external_reset_pin) begin
            s_nxt.st = ST_RESET;
            s_nxt.chip_reset = 1'b1;
            s_nxt.sys_clk_en = 1'b1;
            s_nxt.settle_cnt = 11'h000;
            s_nxt.fixed_cnt = 8'h00;
            s_nxt.pre_cnt = 8'h00;
            s_nxt.sel = WATCHDOG_SELECT_RESET;
            s_nxt.first_seen = 1'b0;
            s_nxt.second_seen = 1'b0;
            s_nxt.cause = WAKE_NONE;
            s_nxt.resume = 1'b0;
            s_nxt.irq_entry = 1'b0;
            s_nxt.warm_reset = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '{
                st: ST_RESET,
                sel: WATCHDOG_SELECT_RESET,
                fixed_cnt: 8'h00,
                pre_cnt: 8'h00,
                instr_div: 2'h0,
                settle_cnt: 11'h000,
                timeout_flag: 1'b0,
                power_down_flag: 1'b0,
                first_seen: 1'b0,
                second_seen: 1'b0,
                // Idle pins read high, so no false falling edge after power-up
                port_prev: 8'hFF,
                irq_mask_at_halt: 8'h00,
                cause: WAKE_NONE,
                chip_reset: 1'b1,
                warm_reset: 1'b0,
                sys_clk_en: 1'b1,
                resume: 1'b0,
                irq_entry: 1'b0,
                rdata: 8'h00
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs are fields of the state register
    assign rdata = s_r.rdata;
    assign chip_reset = s_r.chip_reset;
    assign warm_reset = s_r.warm_reset;
    assign sys_clk_en = s_r.sys_clk_en;
    assign resume = s_r.resume;
    assign irq_entry = s_r.irq_entry;
    assign timeout_flag = s_r.timeout_flag;
    assign power_down_flag = s_r.power_down_flag;

endmodule
`default_nettype wire

// *** verification/wdt_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdt_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rd_stb,
    input wire logic halt_op,
    input wire logic clear_watchdog_op,
    input wire logic first_clear_op,
    input wire logic second_clear_op,
    input wire logic wdt_enable_opt,
    input wire logic [7:0] rdata,
    input wire logic chip_reset,
    input wire logic warm_reset,
    input wire logic sys_clk_en,
    input wire logic resume,
    input wire logic irq_entry,
    input wire logic timeout_flag,
    input wire logic power_down_flag
);
    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic hlt;
    assign hlt = halt_op && sys_clk_en && !chip_reset;
    rdata_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00) else $error("rdata idle");
    halt_stop_a: assert property (hlt |=> !sys_clk_en) else $error("halt clk");
    halt_flags_a: assert property (hlt |=> power_down_flag && !timeout_flag)
        else $error("halt flags");
    pdf_set_a: assert property ($rose(power_down_flag) |-> $past(halt_op)) else $error("pdf set");
    pdf_clear_a: assert property ($fell(power_down_flag) |-> $past(clear_watchdog_op)
        || $past(first_clear_op) || $past(second_clear_op)) else $error("pdf clear");
    to_cause_a: assert property ($rose(timeout_flag) |-> chip_reset || !$past(sys_clk_en))
        else $error("to cause");
    to_off_a: assert property (!wdt_enable_opt && !$past(wdt_enable_opt) |-> !$rose(timeout_flag))
        else $error("to while off");
    warm_pulse_a: assert property (warm_reset |=> !warm_reset) else $error("warm pulse");
    warm_only_a: assert property (warm_reset |-> !chip_reset && timeout_flag)
        else $error("warm kind");
    clk_low_a: assert property ($fell(sys_clk_en) |-> $past(halt_op)) else $error("clk stop");
    // Cycles since the clock came back from halt; zero outside a wake-up
    logic [11:0] wake_cnt_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_cnt_r <= 12'h000;
        end else if (resume || irq_entry || warm_reset) begin
            wake_cnt_r <= 12'h000;
        end else if ($rose(sys_clk_en) && !chip_reset) begin
            wake_cnt_r <= 12'h001;
        end else if (wake_cnt_r != 12'h000 && wake_cnt_r != 12'hFFF) begin
            wake_cnt_r <= wake_cnt_r + 12'h001;
        end
    end
    wake_settle_a: assert property ((resume || irq_entry || warm_reset)
        |-> wake_cnt_r >= 12'h3FC && wake_cnt_r <= 12'h404) else $error("settle");
    wake_due_a: assert property (wake_cnt_r <= 12'h404) else $error("wake late");
    cover property (resume);
    cover property (irq_entry);
    cover property (warm_reset);
endmodule
bind watchdog_halt_wakeup wdt_properties i_wdt_properties (.*);
`default_nettype wire

// *** verification/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic clk,
    output wire logic clear_watchdog_op,
    output wire logic first_clear_op,
    output wire logic second_clear_op,
    output wire logic halt_op,
    output logic rc_osc_tick
);
    // ==========================================
    // Op pulses, one cycle each, a cycle apart
    logic [3:0] ops_r = 4'h0;
    assign {halt_op, second_clear_op, first_clear_op, clear_watchdog_op} = ops_r;
    initial rc_osc_tick = 1'b0;
    task automatic op(input logic [3:0] m);
        @(posedge clk);
        ops_r <= m;
        @(posedge clk);
        ops_r <= 4'h0;
    endtask
    // Both halves must come, else the count runs on
    task automatic dual_clear();
        op(4'h2);
        op(4'h4);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            rc_osc_tick <= 1'b1;
            @(posedge clk);
            rc_osc_tick <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** verification/watchdog_halt_wakeup_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module watchdog_halt_wakeup_tb;
    import wdt_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, en = 1'b1, dual = 1'b0, ie = 1'b0, sf = 1'b0;
    logic wr_stb = 1'b0, rd_stb = 1'b0, clr, f1, f2, hop, rct;
    logic [1:0] src = 2'h0;
    logic xr = 1'b1, xt = 1'b0;
    logic [7:0] wen = 8'h00, pa = 8'hFF, irq = 8'h00, addr = 8'h00, wdata = 8'h00, rdata;
    logic chip_reset, warm_reset, sys_clk_en, resume, irq_entry, timeout_flag, power_down_flag;
    int err_count = 0, checks_done = 0;
    core_model i_core_model (.clk(clk), .clear_watchdog_op(clr), .first_clear_op(f1),
        .second_clear_op(f2), .halt_op(hop), .rc_osc_tick(rct));
    watchdog_halt_wakeup i_watchdog_halt_wakeup (.clk(clk), .rst_b(rst_b),
        .external_reset_pin(xr), .wdt_enable_opt(en), .wdt_src_opt(src),
        .dual_clear_opt(dual), .port_wake_en_opt(wen), .rc_osc_tick(rct), .crystal_tick(xt),
        .clear_watchdog_op(clr), .first_clear_op(f1), .second_clear_op(f2), .halt_op(hop),
        .port_a_in(pa), .irq_pending(irq), .irq_enabled(ie), .stack_full(sf), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .chip_reset(chip_reset),
        .warm_reset(warm_reset), .sys_clk_en(sys_clk_en), .resume(resume), .irq_entry(irq_entry),
        .timeout_flag(timeout_flag), .power_down_flag(power_down_flag));
    initial forever #12.5 clk = ~clk;
    // ==========================================
    // Bus and compare helpers
    task automatic chk(input logic [7:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // Waits stay bounded so a dead block cannot hang the run
    task automatic settle();
        repeat (1200) if (chip_reset) @(posedge clk);
    endtask
    task automatic wake_wait();
        repeat (1200) if (!(resume | irq_entry | warm_reset)) begin @(posedge clk); #1; end
    endtask
    // ==========================================
    // Scenarios
    task automatic s_regs();
        rc(8'h09, 8'h07);
        wr(8'h09, 8'hF8);
        rc(8'h09, 8'hF8);
        wr(8'h0A, 8'hFF);
        rc(8'h0A, 8'h00);
        rc(8'h20, 8'h00);
    endtask
    task automatic s_timeout();
        wr(8'h09, 8'h01);
        i_core_model.ticks(511);
        i_core_model.op(4'h1);
        i_core_model.ticks(511);
        #1 chk(chip_reset, 8'h00);
        i_core_model.ticks(1);
        repeat (3) @(posedge clk);
        #1 chk({timeout_flag, chip_reset}, 8'h03);
        settle();
        rc(8'h09, 8'h07);
        dual <= 1'b1;
        wr(8'h09, 8'h00);
        i_core_model.ticks(200);
        i_core_model.op(4'h2);
        i_core_model.ticks(60);
        #1 chk(chip_reset, 8'h01);
        settle();
        wr(8'h09, 8'h00);
        i_core_model.ticks(200);
        i_core_model.dual_clear();
        i_core_model.ticks(200);
        #1 chk(chip_reset, 8'h00);
        dual <= 1'b0;
    endtask
    task automatic s_port();
        wr(8'h09, 8'h07);
        wen <= 8'h04;
        i_core_model.op(4'h8);
        #1 chk({sys_clk_en, power_down_flag, timeout_flag}, 8'h02);
        pa <= 8'hFD;
        repeat (20) @(posedge clk);
        chk(sys_clk_en, 8'h00);
        pa <= 8'hF9;
        wake_wait();
        chk({resume, irq_entry}, 8'h02);
        pa <= 8'hFF;
        rc(8'h0A, 8'h10);
        rc(8'h09, 8'h07);
        i_core_model.op(4'h1);
        rc(8'h0A, 8'h00);
    endtask
    task automatic s_irq(input logic e, s);
        ie <= e;
        sf <= s;
        irq <= 8'h01;
        i_core_model.op(4'h8);
        repeat (20) @(posedge clk);
        chk(sys_clk_en, 8'h00);
        irq <= 8'h03;
        wake_wait();
        chk({resume, irq_entry}, {6'h00, !(e && !s), e && !s});
        irq <= 8'h00;
    endtask
    task automatic s_wdt_halt();
        wr(8'h09, 8'h08);
        i_core_model.ticks(200);
        i_core_model.op(4'h8);
        i_core_model.ticks(200);
        chk({sys_clk_en, chip_reset}, 8'h00);
        i_core_model.ticks(60);
        wake_wait();
        chk({warm_reset, chip_reset}, 8'h02);
        rc(8'h0A, 8'h30);
        rc(8'h09, 8'h08);
        i_core_model.op(4'h1);
    endtask
    task automatic s_pin_xtal();
        src <= 2'h1;
        wr(8'h09, 8'h02);
        i_core_model.op(4'h1);
        repeat (3) begin
            @(posedge clk);
            xt <= 1'b1;
            @(posedge clk);
            xt <= 1'b0;
        end
        #1 chk(chip_reset, 8'h00);
        @(posedge clk);
        xt <= 1'b1;
        @(posedge clk);
        xt <= 1'b0;
        #1 chk({timeout_flag, chip_reset}, 8'h03);
        @(posedge clk);
        xr <= 1'b0;
        @(posedge clk);
        xr <= 1'b1;
        repeat (1023) @(posedge clk);
        #1 chk(chip_reset, 8'h01);
        @(posedge clk);
        #1 chk(chip_reset, 8'h00);
        rc(8'h09, 8'h07);
        wr(8'h09, 8'h0F);
        @(posedge clk);
        xr <= 1'b0;
        @(posedge clk);
        xr <= 1'b1;
        #1 chk(chip_reset, 8'h01);
        settle();
        rc(8'h09, 8'h07);
        rc(8'h0A, 8'h20);
        src <= 2'h0;
        i_core_model.op(4'h1);
        rc(8'h0A, 8'h00);
    endtask
    task automatic s_off_instr();
        en <= 1'b0;
        wr(8'h09, 8'h00);
        i_core_model.ticks(600);
        chk({timeout_flag, chip_reset}, 8'h00);
        en <= 1'b1;
        wr(8'h09, 8'h07);
        src <= 2'h2;
        i_core_model.op(4'h1);
        i_core_model.op(4'h8);
        repeat (2000) @(posedge clk);
        chk({timeout_flag, warm_reset, chip_reset}, 8'h00);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk(chip_reset, 8'h01);
        settle();
        s_regs();
        s_timeout();
        s_port();
        s_irq(1'b1, 1'b0);
        s_irq(1'b1, 1'b1);
        s_irq(1'b0, 1'b0);
        s_wdt_halt();
        s_pin_xtal();
        s_off_instr();
        wrap_up();
    end
    initial begin
        #(40000 * 25);
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
